// File: logic/srr_pkg.sv
package srr_pkg;

  localparam int SRR_W = 8;
  localparam logic [7:0] SRR_RST_BYTE = 8'h00;

  // summary byte fields
  localparam int SUM_MASTER = 6;
  localparam int SUM_EVENT  = 5;
  localparam int SUM_DEVICE = 4;
  localparam logic [7:0] SRM_USED = 8'h30;
  // standard event flags
  localparam int EV_CMD = 5;
  localparam int EV_RUN = 4;
  localparam logic [7:0] EV_USED = 8'h30;
  // device state flags
  localparam int DS_STOP  = 6;
  localparam int DS_FAIL  = 5;
  localparam int DS_PASS  = 4;
  localparam int DS_HV    = 3;
  localparam int DS_TEST  = 2;
  localparam int DS_INV   = 1;
  localparam int DS_READY = 0;
  localparam logic [7:0] DS_USED = 8'h7f;
  // limit failure flags
  localparam int LF_UPPER = 2;
  localparam int LF_LOWER = 1;
  // invalid setting flags
  localparam int IS_FIXUP = 4;
  localparam int IS_WAIT  = 3;
  localparam int IS_ORDER = 2;
  localparam int IS_CURR  = 1;
  // message error flags
  localparam int CF_STATE  = 3;
  localparam int CF_RANGE  = 2;
  localparam int CF_DATA   = 1;
  localparam int CF_HEADER = 0;

  // current check: lower limit lsb is 10 kohm, limit in tenths of a mA
  localparam int LOW_LSB_KOHM  = 10;
  localparam int CUR_LIM_TENTH = 11;
  localparam int VOLT_SCALE    = 10;
  localparam logic [9:0] WR_MAX = 10'h0ff;

  typedef enum logic [3:0] {
    OP_NONE, OP_CLEAR, OP_RD_SUM, OP_WR_SRM, OP_RD_SRM, OP_RD_EV,
    OP_WR_DSM, OP_RD_DSM, OP_RD_DS, OP_RD_LF, OP_RD_IS, OP_RD_CF
  } srr_op_t;

  typedef struct packed {
    logic       valid;
    srr_op_t    op;
    logic       hex;
    logic [3:0] d2;
    logic [3:0] d1;
    logic [3:0] d0;
  } srr_req_t;

  typedef struct packed {
    logic header_err;
    logic data_err;
    logic range_err;
    logic bad_state_msg;
    logic test_running;
    logic upper_fail;
    logic lower_fail;
  } srr_evt_t;

  typedef struct packed {
    logic test_stopped;
    logic fail_judged;
    logic pass_judged;
    logic high_voltage_output_active;
    logic test_voltage_on;
    logic ready;
  } srr_dev_t;

  typedef struct packed {
    logic        fixed_range;
    logic        upper_judge_on;
    logic        lower_judge_on;
    logic        timer_on;
    logic [13:0] wait_time;
    logic [13:0] test_time;
    logic [18:0] lower_limit;
    logic [18:0] upper_limit;
    logic [9:0]  test_volt;
  } srr_set_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] value;
    logic [3:0] hund;
    logic [3:0] tens;
    logic [3:0] ones;
  } srr_rsp_t;

  typedef struct packed {
    logic [7:0] srm;
    logic [7:0] dsm;
    logic [7:0] ev;
    logic [7:0] ds;
    logic [7:0] lf;
    logic [7:0] is;
    logic [7:0] cf;
    logic [7:0] sum;
    srr_rsp_t   rsp;
  } srr_state_t;

endpackage

// File: logic/srr_regs.sv
`timescale 1ns/1ns
module srr_regs
  import srr_pkg::*;
(
  input  wire logic     clk_sys,
  input  wire logic     rstn,
  input  wire srr_req_t req,
  input  wire srr_evt_t evt,
  input  wire srr_dev_t dev,
  input  wire srr_set_t set,
  output srr_rsp_t      rsp,
  output logic [7:0]    status_summary_byte,
  output logic          master_summary_flag
);

  srr_state_t s_q;
  srr_state_t s_d;

  logic [9:0]  wr_val;
  logic        wr_op;
  logic        wr_data_bad;
  logic        wr_range_bad;
  logic [7:0]  is_now;
  logic [7:0]  ev_set;
  logic [7:0]  cf_set;
  logic [7:0]  lf_set;
  logic [7:0]  rd_val;
  logic        clr_all;
  logic        rd_ev;
  logic        rd_cf;
  logic [31:0] cur_lhs;
  logic [31:0] cur_rhs;

  // everything settles in one pass; the answer leaves one cycle after the request
  always_comb begin
    s_d = s_q;
    // write value: hex takes two digits, decimal three
    wr_op = req.valid && (req.op == OP_WR_SRM || req.op == OP_WR_DSM);
    if (req.hex) begin
      wr_val      = {2'b00, req.d1, req.d0};
      wr_data_bad = 1'b0;
      wr_range_bad = (req.d2 != 4'h0);
    end else begin
      wr_val = 10'(req.d2) * 10'd100 + 10'(req.d1) * 10'd10 + 10'(req.d0);
      wr_data_bad  = (req.d2 > 4'h9) || (req.d1 > 4'h9) || (req.d0 > 4'h9);
      wr_range_bad = !wr_data_bad && (wr_val > WR_MAX);
    end
    wr_data_bad  = wr_data_bad && wr_op;
    wr_range_bad = wr_range_bad && wr_op;

    // invalid setting conditions, live from the settings
    is_now = SRR_RST_BYTE;
    is_now[IS_FIXUP] = set.fixed_range && set.upper_judge_on;
    is_now[IS_WAIT]  = set.timer_on && (set.wait_time >= set.test_time);
    is_now[IS_ORDER] = set.upper_judge_on && set.lower_judge_on &&
                       (set.lower_limit >= set.upper_limit);
    // current in tenths of a mA compared without a divider
    cur_lhs = 32'(set.test_volt) * 32'(VOLT_SCALE);
    cur_rhs = 32'(set.lower_limit) * 32'(CUR_LIM_TENTH * LOW_LSB_KOHM);
    is_now[IS_CURR] = (set.lower_limit != 19'h0) && (cur_lhs > cur_rhs);
    s_d.is = is_now;

    // device state levels, bit 7 stays zero
    s_d.ds = SRR_RST_BYTE;
    s_d.ds[DS_STOP]  = dev.test_stopped;
    s_d.ds[DS_FAIL]  = dev.fail_judged;
    s_d.ds[DS_PASS]  = dev.pass_judged;
    s_d.ds[DS_HV]    = dev.high_voltage_output_active;
    s_d.ds[DS_TEST]  = dev.test_voltage_on;
    s_d.ds[DS_READY] = dev.ready;
    s_d.ds[DS_INV]   = |is_now;

    // new events this cycle
    ev_set = SRR_RST_BYTE;
    ev_set[EV_CMD] = evt.header_err || evt.data_err || evt.range_err ||
                     wr_data_bad || wr_range_bad;
    ev_set[EV_RUN] = evt.bad_state_msg && evt.test_running;
    cf_set = SRR_RST_BYTE;
    cf_set[CF_STATE]  = evt.bad_state_msg;
    cf_set[CF_RANGE]  = evt.range_err || wr_range_bad;
    cf_set[CF_DATA]   = evt.data_err || wr_data_bad;
    cf_set[CF_HEADER] = evt.header_err;
    lf_set = SRR_RST_BYTE;
    lf_set[LF_UPPER] = evt.upper_fail;
    lf_set[LF_LOWER] = evt.lower_fail;

    // sticky flags; a new event in the clearing cycle survives the clear
    clr_all = req.valid && (req.op == OP_CLEAR);
    rd_ev   = req.valid && (req.op == OP_RD_EV);
    rd_cf   = req.valid && (req.op == OP_RD_CF);
    s_d.ev = ((clr_all || rd_ev) ? SRR_RST_BYTE : s_q.ev) | ev_set;
    s_d.cf = ((clr_all || rd_cf) ? SRR_RST_BYTE : s_q.cf) | cf_set;
    s_d.lf = (clr_all ? SRR_RST_BYTE : s_q.lf) | lf_set;

    // mask writes keep only bits that mean something
    if (req.valid && req.op == OP_WR_SRM && !wr_data_bad && !wr_range_bad) begin
      s_d.srm = wr_val[7:0] & SRM_USED;
    end
    if (req.valid && req.op == OP_WR_DSM && !wr_data_bad && !wr_range_bad) begin
      s_d.dsm = wr_val[7:0] & DS_USED;
    end

    // summary from the next flag values so it never lags them
    s_d.sum = SRR_RST_BYTE;
    s_d.sum[SUM_EVENT]  = |s_d.ev;
    s_d.sum[SUM_DEVICE] = |(s_d.ds & s_d.dsm);
    s_d.sum[SUM_MASTER] = |(s_d.sum & s_d.srm);

    // query answer holds the value before any read clear
    rd_val = SRR_RST_BYTE;
    case (req.op)
      OP_RD_SUM: rd_val = s_q.sum;
      OP_RD_SRM: rd_val = s_q.srm;
      OP_RD_EV:  rd_val = s_q.ev;
      OP_RD_DSM: rd_val = s_q.dsm;
      OP_RD_DS:  rd_val = s_q.ds;
      OP_RD_LF:  rd_val = s_q.lf;
      OP_RD_IS:  rd_val = s_q.is;
      OP_RD_CF:  rd_val = s_q.cf;
      default:   rd_val = SRR_RST_BYTE;
    endcase
    s_d.rsp.valid = req.valid && (req.op == OP_RD_SUM || req.op == OP_RD_SRM ||
                    req.op == OP_RD_EV || req.op == OP_RD_DSM || req.op == OP_RD_DS ||
                    req.op == OP_RD_LF || req.op == OP_RD_IS || req.op == OP_RD_CF);
    if (s_d.rsp.valid) begin
      s_d.rsp.value = rd_val;
      // decimal digits whatever radix wrote it
      s_d.rsp.hund = 4'(rd_val / 8'd100);
      s_d.rsp.tens = 4'((rd_val / 8'd10) % 8'd10);
      s_d.rsp.ones = 4'(rd_val % 8'd10);
    end
  end

  // masks live only in flip-flops, so reset and power loss both clear them
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state flip-flops
  assign rsp                 = s_q.rsp;
  assign status_summary_byte = s_q.sum;
  assign master_summary_flag = s_q.sum[SUM_MASTER];

  // checks on the register bank
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  master_summary_a: assert property (s_q.sum[SUM_MASTER] == |(s_q.sum[5:4] & s_q.srm[5:4]))
    else $error("master summary does not follow masked summary bits");
  event_summary_a: assert property (s_q.sum[SUM_EVENT] == |s_q.ev)
    else $error("event summary bit wrong");
  cmd_fault_a: assert property (evt.range_err || evt.data_err || evt.header_err |=> s_q.ev[EV_CMD])
    else $error("command fault flag not set");
  run_fault_a: assert property (evt.bad_state_msg && evt.test_running |=> s_q.ev[EV_RUN] && s_q.cf[CF_STATE])
    else $error("run time fault flag not set");
  inv_state_a: assert property (s_q.ds[DS_INV] == |s_q.is)
    else $error("invalid setting state bit wrong");
  upper_fail_a: assert property (evt.upper_fail |=> s_q.lf[LF_UPPER] until_with (req.valid && req.op == OP_CLEAR))
    else $error("upper failure flag lost");
  cur_limit_a: assert property ((set.lower_limit != 19'h0) &&
      (32'(set.test_volt) > 32'(set.lower_limit) * 32'd11)
      |=> s_q.is[IS_CURR])
    else $error("current limit flag not set");
  hex_write_a: assert property (req.valid && req.op == OP_WR_SRM && req.hex && req.d2 == 4'h0
      |=> s_q.srm == ($past(({req.d1, req.d0})) & SRM_USED))
    else $error("hex mask write not taken");
  dec_answer_a: assert property (req.valid && req.op == OP_RD_SUM |=> rsp.valid &&
      (8'(rsp.hund) * 8'd100 + 8'(rsp.tens) * 8'd10 + 8'(rsp.ones) == rsp.value))
    else $error("answer digits do not match value");
  ev_readclr_a: assert property (rd_ev && ev_set == 8'h00 |=> s_q.ev == 8'h00 && rsp.value == $past(s_q.ev))
    else $error("event flags not cleared by query");
  cf_readclr_a: assert property (rd_cf && cf_set == 8'h00 |=> s_q.cf == 8'h00 && rsp.value == $past(s_q.cf))
    else $error("message error flags not cleared by query");
  unused_zero_a: assert property ((s_q.ev & ~EV_USED) == 8'h00 && s_q.ds[7] == 1'b0 &&
      (s_q.srm & ~SRM_USED) == 8'h00 && s_q.is[0] == 1'b0)
    else $error("unused bit reads one");

  hex_write_c: cover property (req.valid && req.op == OP_WR_SRM && req.hex ##1 s_q.srm != 8'h00);
  master_rise_c: cover property (!s_q.sum[SUM_MASTER] ##1 s_q.sum[SUM_MASTER]);
  ev_read_c:   cover property (s_q.ev != 8'h00 && rd_ev ##1 rsp.valid);
  set_clr_c:   cover property (rd_cf && cf_set != 8'h00);

endmodule // srr_regs

// File: tb/srr_host.sv
`timescale 1ns/1ns
module srr_host
  import srr_pkg::*;
(
  input  wire logic clk_sys,
  output srr_req_t  req
);
  // idle command port until the host speaks
  initial req = '0;

  // one command per two cycles, so valid never changes twice in a step
  task automatic send(input srr_op_t op, input logic hex, input logic [9:0] v);
    logic [11:0] d;
    // hex marker carries two digits, decimal carries three
    d = hex ? {4'h0, v[7:4], v[3:0]} : {4'(v / 10'h064), 4'(v / 10'h00a % 10'h00a), 4'(v % 10'h00a)};
    @(posedge clk_sys);
    req <= '{1'b1, op, hex, d[11:8], d[7:4], d[3:0]};
    @(posedge clk_sys);
    req.valid <= 1'b0;
  endtask
endmodule // srr_host

// File: tb/tb.sv
`timescale 1ns/1ns
module tb
  import srr_pkg::*;
;
  logic       clk_sys;
  logic       rstn;
  srr_req_t   req;
  srr_evt_t   evt;
  srr_dev_t   dev;
  srr_set_t   set;
  srr_rsp_t   rsp;
  logic [7:0] status_summary_byte;
  logic       master_summary_flag;
  logic [7:0] expq[$];
  logic [7:0] e;
  logic [5:0] dv;
  int         n_fail = 0;
  int         n_checks = 0;
  int         seed;

  srr_host u_host (.clk_sys(clk_sys), .req(req));
  srr_regs dut (.clk_sys(clk_sys), .rstn(rstn), .req(req), .evt(evt), .dev(dev), .set(set), .rsp(rsp),
                .status_summary_byte(status_summary_byte), .master_summary_flag(master_summary_flag));

  // 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // note first, so the answer never outruns its note
  task automatic rd(input srr_op_t op, input logic [7:0] exp);
    expq.push_back(exp);
    u_host.send(op, 1'b0, 10'h000);
  endtask

  // one-cycle fault pulse; the running level is kept
  task automatic pulse(input srr_evt_t p);
    @(posedge clk_sys);
    evt <= p;
    @(posedge clk_sys);
    evt <= p & 7'h04;
  endtask

  // settings are live levels: flag, device bit 1 and summary follow
  task automatic inv(input srr_set_t s, input logic [7:0] exp);
    @(posedge clk_sys);
    set <= s;
    rd(OP_RD_IS, exp);
    rd(OP_RD_DS, {6'h00, |exp, 1'b0});
    rd(OP_RD_SUM, {1'b0, |exp, 1'b0, |exp, 4'h0});
  endtask

  // take the oldest note on each answer; digits follow from the noted value
  always @(posedge clk_sys) begin
    if (rstn === 1'b1 && rsp.valid === 1'b1) begin
      if (expq.size() == 0) begin
        chk(8'hxx, 8'h00);
      end else begin
        e = expq.pop_front();
        chk(rsp.value, e);
        chk({rsp.tens, rsp.ones}, {4'(e / 8'h0a % 8'h0a), 4'(e % 8'h0a)});
        chk({4'h0, rsp.hund}, e / 8'h64);
      end
    end
  end

  // a hang is cut short here
  initial begin
    #200000;
    n_fail++;
    end_sim();
  end

  initial begin
    seed = 32'hde1c;
    rstn = 1'b0;
    evt = '0;
    dev = '0;
    set = '0;
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    // every readable register starts at zero
    for (int i = 2; i < 12; i++) begin
      if (i != 3 && i != 6) begin
        rd(srr_op_t'(i), 8'h00);
      end
    end
    // hex marker write, then a decimal one; unused mask bits are dropped
    u_host.send(OP_WR_SRM, 1'b1, 10'h0ff);
    rd(OP_RD_SRM, 8'h30);
    u_host.send(OP_WR_DSM, 1'b0, 10'h0ff);
    rd(OP_RD_DSM, 8'h7f);
    // value above a byte is refused but flagged
    u_host.send(OP_WR_SRM, 1'b0, 10'h12c);
    rd(OP_RD_SRM, 8'h30);
    rd(OP_RD_SUM, 8'h60);
    chk(8'(master_summary_flag), 8'h01);
    chk(status_summary_byte, 8'h60);
    rd(OP_RD_CF, 8'h04);
    rd(OP_RD_EV, 8'h20);
    rd(OP_RD_EV, 8'h00);
    rd(OP_RD_CF, 8'h00);
    // header, data, range, forbidden-while-running
    for (int i = 0; i < 4; i++) begin
      pulse(srr_evt_t'((7'h40 >> i) | (i == 3 ? 7'h04 : 7'h00)));
      rd(OP_RD_EV, i == 3 ? 8'h10 : 8'h20);
      rd(OP_RD_CF, 8'h08 >> (3 - i));
    end
    pulse(srr_evt_t'(7'h00));
    // limit failures stay until the clear command
    pulse(srr_evt_t'(7'h02));
    pulse(srr_evt_t'(7'h01));
    rd(OP_RD_LF, 8'h06);
    rd(OP_RD_LF, 8'h06);
    u_host.send(OP_CLEAR, 1'b0, 10'h000);
    rd(OP_RD_LF, 8'h00);
    // each invalid setting alone, then the current boundary
    inv('{1'b1, 1'b1, 1'b0, 1'b0, 14'h0, 14'h0, 19'h0, 19'h0, 10'h0}, 8'h10);
    inv('{1'b0, 1'b0, 1'b0, 1'b1, 14'h5, 14'h5, 19'h0, 19'h0, 10'h0}, 8'h08);
    inv('{1'b0, 1'b1, 1'b1, 1'b0, 14'h0, 14'h0, 19'h3, 19'h3, 10'h0}, 8'h04);
    inv('{1'b0, 1'b0, 1'b0, 1'b0, 14'h0, 14'h0, 19'h1, 19'h0, 10'h00c}, 8'h02);
    inv('{1'b0, 1'b0, 1'b0, 1'b0, 14'h0, 14'h0, 19'h1, 19'h0, 10'h00b}, 8'h00);
    // random device levels land on their bit positions
    for (int i = 0; i < 4; i++) begin
      dv = 6'($random(seed));
      @(posedge clk_sys);
      dev <= srr_dev_t'(dv);
      rd(OP_RD_DS, {1'b0, dv[5:1], 1'b0, dv[0]});
      rd(OP_RD_SUM, {1'b0, |dv, 1'b0, |dv, 4'h0});
    end
    // a cleared service mask silences the master bit
    u_host.send(OP_WR_SRM, 1'b1, 10'h000);
    rd(OP_RD_SUM, {3'h0, |dv, 4'h0});
    chk(8'(master_summary_flag), 8'h00);
    chk(status_summary_byte, {3'h0, |dv, 4'h0});
    // masks do not survive a reset
    u_host.send(OP_WR_SRM, 1'b0, 10'h030);
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    rd(OP_RD_SRM, 8'h00);
    rd(OP_RD_DSM, 8'h00);
    for (int k = 0; k < 20 && expq.size() != 0; k++) begin
      @(posedge clk_sys);
    end
    if (expq.size() != 0) begin
      n_fail++;
    end
    end_sim();
  end
endmodule // tb
